// file: verilog/mipc_pkg.sv
// Shared constants and carrier types of the interrupt and power control block
package mipc_pkg;

    localparam int MIPC_NSRC = 6;

    // Source indices, also the bit positions in enable, priority, status and mask
    localparam int MIPC_SRC_EXT0 = 0;
    localparam int MIPC_SRC_TMR0 = 1;
    localparam int MIPC_SRC_EXT1 = 2;
    localparam int MIPC_SRC_TMR1 = 3;
    localparam int MIPC_SRC_SER = 4;
    localparam int MIPC_SRC_TMR2 = 5;

    // Register byte addresses
    localparam logic [7:0] MIPC_ADDR_POWER = 8'h00;
    localparam logic [7:0] MIPC_ADDR_ENABLE = 8'h04;
    localparam logic [7:0] MIPC_ADDR_PRIORITY = 8'h08;
    localparam logic [7:0] MIPC_ADDR_EXT_CTRL = 8'h0C;
    localparam logic [7:0] MIPC_ADDR_STATUS = 8'h10;
    localparam logic [7:0] MIPC_ADDR_MASK = 8'h14;
    localparam logic [7:0] MIPC_ADDR_STATE = 8'h18;

    // Power control fields
    localparam int MIPC_PC_SLEEP = 0;
    localparam int MIPC_PC_PDOWN = 1;
    localparam int MIPC_PC_FLAG0 = 2;
    localparam int MIPC_PC_FLAG1 = 3;
    localparam int MIPC_PC_BAUD2 = 7;
    localparam logic [7:0] MIPC_PC_WMASK = 8'h8F;

    // Enable and priority fields
    localparam int MIPC_EN_GLOBAL = 7;
    localparam logic [7:0] MIPC_EN_WMASK = 8'hBF;
    localparam logic [7:0] MIPC_PRI_WMASK = 8'h3F;

    // External trigger control fields
    localparam int MIPC_EC_EDGE0 = 0;
    localparam int MIPC_EC_EDGE1 = 1;
    localparam logic [7:0] MIPC_EC_WMASK = 8'h03;

    // Reset values
    localparam logic [7:0] MIPC_RST_REG8 = 8'h00;

    // Vector addresses
    localparam logic [15:0] MIPC_VEC_EXT0 = 16'h0003;
    localparam logic [15:0] MIPC_VEC_TMR0 = 16'h000B;
    localparam logic [15:0] MIPC_VEC_EXT1 = 16'h0013;
    localparam logic [15:0] MIPC_VEC_TMR1 = 16'h001B;
    localparam logic [15:0] MIPC_VEC_SER = 16'h0023;
    localparam logic [15:0] MIPC_VEC_TMR2 = 16'h002B;

    // Bus responses
    localparam logic [1:0] MIPC_RESP_OKAY = 2'b00;
    localparam logic [1:0] MIPC_RESP_DECERR = 2'b11;

    // Peripheral event flags, same clock as the block
    typedef struct packed {
        logic timer2_external_flag;
        logic timer2_overflow_flag;
        logic tx_done_flag;
        logic rx_done_flag;
        logic timer1_overflow_flag;
        logic timer0_overflow_flag;
    } mipc_flags_t;

    // Power control outputs to clock gating and serial logic
    typedef struct packed {
        logic baud_double;
        logic power_down_request;
        logic sleep_request;
    } mipc_power_t;

endpackage

// file: verilog/mipc_ext_cond.sv
// External interrupt pin conditioner: synchroniser, level or falling edge
`timescale 1ns/1ns
module mipc_ext_cond (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    input wire logic edge_select,
    input wire logic flag_clear,
    output logic request
);
    logic sync_a;
    logic sync_b;
    logic pin_prev;
    logic edge_flag;
    logic next_edge_flag;
    logic next_request;

    always_comb begin
        next_edge_flag = edge_flag;
        if (flag_clear) begin
            next_edge_flag = 1'b0;
        end
        // Edge set wins over a clear in the same cycle
        if (pin_prev && !sync_b) begin
            next_edge_flag = 1'b1;
        end
        if (!edge_select) begin
            next_edge_flag = 1'b0;
        end
        // Low level requests in level mode, latched fall in edge mode
        next_request = edge_select ? next_edge_flag : !sync_b;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            pin_prev <= 1'b1;
            edge_flag <= 1'b0;
            request <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
            pin_prev <= sync_b;
            edge_flag <= next_edge_flag;
            request <= next_request;
        end
    end
endmodule

// file: verilog/mipc_top.sv
// Interrupt enable, two-level priority, vectoring and power control with AXI4-Lite
`timescale 1ns/1ns
module mipc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext0_pin,
    input wire logic ext1_pin,
    input wire mipc_pkg::mipc_flags_t flags,
    input wire logic int_ack,
    input wire logic int_return,
    output logic int_req,
    output logic [15:0] int_vector,
    output logic timer0_flag_clear,
    output logic timer1_flag_clear,
    output mipc_pkg::mipc_power_t power,
    output logic irq
);
    import mipc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] power_control_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] interrupt_priority_reg;
    logic [7:0] ext_ctrl_reg;
    logic [5:0] status_reg;
    logic [5:0] mask_reg;
    logic active_high;
    logic active_low;
    logic [2:0] sel_src;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;

    logic [7:0] next_power_control_reg;
    logic [7:0] next_interrupt_enable_reg;
    logic [7:0] next_interrupt_priority_reg;
    logic [7:0] next_ext_ctrl_reg;
    logic [5:0] next_status_reg;
    logic [5:0] next_mask_reg;
    logic next_active_high;
    logic next_active_low;
    logic [2:0] next_sel_src;
    logic next_int_req;
    logic [15:0] next_int_vector;
    logic next_timer0_flag_clear;
    logic next_timer1_flag_clear;
    logic next_aw_full;
    logic next_w_full;
    logic [7:0] next_aw_addr;
    logic [7:0] next_w_data;
    logic next_w_lane0;
    logic next_awready;
    logic next_wready;
    logic [1:0] next_bresp;
    logic next_bvalid;
    logic next_arready;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid;
    mipc_power_t next_power;
    logic next_irq;

    logic ext0_req;
    logic ext1_req;
    logic ext0_clear;
    logic ext1_clear;

    ////////////////////////////////////////////////////////////////////////////
    // External pin conditioners
    mipc_ext_cond u_ext0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(ext0_pin),
        .edge_select(ext_ctrl_reg[MIPC_EC_EDGE0]),
        .flag_clear(ext0_clear),
        .request(ext0_req)
    );

    mipc_ext_cond u_ext1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(ext1_pin),
        .edge_select(ext_ctrl_reg[MIPC_EC_EDGE1]),
        .flag_clear(ext1_clear),
        .request(ext1_req)
    );

    function automatic logic [15:0] vector_of(input logic [2:0] src);
        logic [15:0] v;
        case (src)
            3'h0: v = MIPC_VEC_EXT0;
            3'h1: v = MIPC_VEC_TMR0;
            3'h2: v = MIPC_VEC_EXT1;
            3'h3: v = MIPC_VEC_TMR1;
            3'h4: v = MIPC_VEC_SER;
            default: v = MIPC_VEC_TMR2;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration, vectoring and power
    logic [5:0] raw_req;
    logic [5:0] pending;
    logic [5:0] cand;
    logic accept;
    logic accept_high;
    logic [7:0] rd_val;
    logic rd_hit;
    logic wr_do;
    logic wr_hit;

    assign ext0_clear = accept && (sel_src == 3'(MIPC_SRC_EXT0));
    assign ext1_clear = accept && (sel_src == 3'(MIPC_SRC_EXT1));

    always_comb begin
        raw_req = '0;
        raw_req[MIPC_SRC_EXT0] = ext0_req;
        raw_req[MIPC_SRC_TMR0] = flags.timer0_overflow_flag;
        raw_req[MIPC_SRC_EXT1] = ext1_req;
        raw_req[MIPC_SRC_TMR1] = flags.timer1_overflow_flag;
        raw_req[MIPC_SRC_SER] = flags.rx_done_flag | flags.tx_done_flag;
        raw_req[MIPC_SRC_TMR2] = flags.timer2_overflow_flag | flags.timer2_external_flag;
        pending = raw_req & interrupt_enable_reg[5:0];
        if (!interrupt_enable_reg[MIPC_EN_GLOBAL]) begin
            pending = '0;
        end
        // High level only while no high service runs; low only while idle
        cand = '0;
        if (!active_high && |(pending & interrupt_priority_reg[5:0])) begin
            cand = pending & interrupt_priority_reg[5:0];
        end else if (!active_high && !active_low) begin
            cand = pending & ~interrupt_priority_reg[5:0];
        end
        next_sel_src = sel_src;
        for (int i = MIPC_NSRC - 1; i >= 0; i--) begin
            if (cand[i]) begin
                next_sel_src = 3'(i);
            end
        end
        accept = int_req && int_ack;
        accept_high = interrupt_priority_reg[sel_src];
        next_int_req = |cand && !accept;
        next_int_vector = vector_of(next_sel_src);
        next_active_high = active_high;
        next_active_low = active_low;
        if (int_return) begin
            if (active_high) begin
                next_active_high = 1'b0;
            end else begin
                next_active_low = 1'b0;
            end
        end
        if (accept) begin
            if (accept_high) begin
                next_active_high = 1'b1;
            end else begin
                next_active_low = 1'b1;
            end
        end
        next_timer0_flag_clear = accept && (sel_src == 3'(MIPC_SRC_TMR0));
        next_timer1_flag_clear = accept && (sel_src == 3'(MIPC_SRC_TMR1));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_power_control_reg = power_control_reg;
        next_interrupt_enable_reg = interrupt_enable_reg;
        next_interrupt_priority_reg = interrupt_priority_reg;
        next_ext_ctrl_reg = ext_ctrl_reg;
        next_mask_reg = mask_reg;
        next_status_reg = status_reg;
        rd_val = '0;
        rd_hit = 1'b1;
        wr_hit = 1'b1;

        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata[7:0];
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        wr_do = aw_full && w_full && !s_axi_bvalid;
        if (wr_do) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            case (aw_addr)
                MIPC_ADDR_POWER: begin
                    if (w_lane0) begin
                        // Flags and baud bit are plain storage
                        next_power_control_reg = w_data & MIPC_PC_WMASK;
                    end
                end
                MIPC_ADDR_ENABLE: begin
                    if (w_lane0) begin
                        next_interrupt_enable_reg = w_data & MIPC_EN_WMASK;
                    end
                end
                MIPC_ADDR_PRIORITY: begin
                    if (w_lane0) begin
                        next_interrupt_priority_reg = w_data & MIPC_PRI_WMASK;
                    end
                end
                MIPC_ADDR_EXT_CTRL: begin
                    if (w_lane0) begin
                        next_ext_ctrl_reg = w_data & MIPC_EC_WMASK;
                    end
                end
                MIPC_ADDR_STATUS: begin
                    if (w_lane0) begin
                        next_status_reg = status_reg & ~w_data[5:0];
                    end
                end
                MIPC_ADDR_MASK: begin
                    if (w_lane0) begin
                        next_mask_reg = w_data[5:0];
                    end
                end
                MIPC_ADDR_STATE: begin
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            next_bresp = wr_hit ? MIPC_RESP_OKAY : MIPC_RESP_DECERR;
        end

        // Accepted sources set sticky status; set wins over clear
        if (accept) begin
            next_status_reg[sel_src] = 1'b1;
            // Any accepted interrupt ends sleep
            next_power_control_reg[MIPC_PC_SLEEP] = 1'b0;
        end
        // Enabled external request wakes from power-down, with the global enable set
        if (pending[MIPC_SRC_EXT0] || pending[MIPC_SRC_EXT1]) begin
            next_power_control_reg[MIPC_PC_PDOWN] = 1'b0;
        end

        case (s_axi_araddr)
            MIPC_ADDR_POWER: rd_val = power_control_reg;
            MIPC_ADDR_ENABLE: rd_val = interrupt_enable_reg;
            MIPC_ADDR_PRIORITY: rd_val = interrupt_priority_reg;
            MIPC_ADDR_EXT_CTRL: rd_val = ext_ctrl_reg;
            MIPC_ADDR_STATUS: rd_val = {2'h0, status_reg};
            MIPC_ADDR_MASK: rd_val = {2'h0, mask_reg};
            MIPC_ADDR_STATE: rd_val = {int_req, active_high, active_low, 2'h0, sel_src};
            default: rd_hit = 1'b0;
        endcase
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = {24'h000000, rd_val};
            next_rresp = rd_hit ? MIPC_RESP_OKAY : MIPC_RESP_DECERR;
        end

        next_awready = !next_aw_full && !next_bvalid;
        next_wready = !next_w_full && !next_bvalid;
        next_arready = !next_rvalid;
        next_irq = |(next_status_reg & next_mask_reg);

        // Power-down takes precedence when both bits are set
        next_power.power_down_request = next_power_control_reg[MIPC_PC_PDOWN];
        next_power.sleep_request = next_power_control_reg[MIPC_PC_SLEEP]
            && !next_power_control_reg[MIPC_PC_PDOWN];
        next_power.baud_double = next_power_control_reg[MIPC_PC_BAUD2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_control_reg <= MIPC_RST_REG8;
            interrupt_enable_reg <= MIPC_RST_REG8;
            interrupt_priority_reg <= MIPC_RST_REG8;
            ext_ctrl_reg <= MIPC_RST_REG8;
            status_reg <= '0;
            mask_reg <= '0;
            active_high <= 1'b0;
            active_low <= 1'b0;
            sel_src <= '0;
            int_req <= 1'b0;
            int_vector <= MIPC_VEC_EXT0;
            timer0_flag_clear <= 1'b0;
            timer1_flag_clear <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= MIPC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= MIPC_RESP_OKAY;
            power <= '0;
            irq <= 1'b0;
        end else begin
            power_control_reg <= next_power_control_reg;
            interrupt_enable_reg <= next_interrupt_enable_reg;
            interrupt_priority_reg <= next_interrupt_priority_reg;
            ext_ctrl_reg <= next_ext_ctrl_reg;
            status_reg <= next_status_reg;
            mask_reg <= next_mask_reg;
            active_high <= next_active_high;
            active_low <= next_active_low;
            sel_src <= next_sel_src;
            int_req <= next_int_req;
            int_vector <= next_int_vector;
            timer0_flag_clear <= next_timer0_flag_clear;
            timer1_flag_clear <= next_timer1_flag_clear;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            power <= next_power;
            irq <= next_irq;
        end
    end
endmodule

// file: tb/mipc_cpu_model.sv
// Core sequencer model: takes offered vectors and signals returns
`timescale 1ns/1ns
module mipc_cpu_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic int_req,
    input wire logic [15:0] int_vector,
    input wire logic [3:0] lag,
    input wire logic ret_cmd,
    output logic int_ack,
    output logic int_return,
    output logic [15:0] got_vec
);
    logic [3:0] cnt;

    // Ack only while an offer stands, after lag cycles
    always @(posedge aclk) begin
        int_return <= ret_cmd && aresetn;
        if (!aresetn || !int_req || int_ack) begin
            int_ack <= 1'h0;
            cnt <= 4'h0;
        end else if (cnt == lag) begin
            int_ack <= 1'h1;
            got_vec <= int_vector;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// file: tb/mipc_top_sva.sv
// Port-level checker of the interrupt and power control block
`timescale 1ns/1ns
module mipc_top_sva
    import mipc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic int_ack,
    input wire logic int_req,
    input wire logic [15:0] int_vector,
    input wire logic timer0_flag_clear,
    input wire logic timer1_flag_clear,
    input wire mipc_pkg::mipc_power_t power
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    // Shadow of the global enable from completed writes
    logic [7:0] wa;
    logic wd;
    logic ge;
    logic vec_ok;
    logic take0;
    logic take1;
    assign vec_ok = int_vector inside {MIPC_VEC_EXT0, MIPC_VEC_TMR0, MIPC_VEC_EXT1,
        MIPC_VEC_TMR1, MIPC_VEC_SER, MIPC_VEC_TMR2};
    assign take0 = int_req && int_ack && int_vector == MIPC_VEC_TMR0;
    assign take1 = int_req && int_ack && int_vector == MIPC_VEC_TMR1;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wa <= 8'h00;
            wd <= 1'h0;
            ge <= 1'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wa <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd <= s_axi_wstrb[0] ? s_axi_wdata[MIPC_EN_GLOBAL] : ge;
            end
            if (s_axi_bvalid && s_axi_bready && wa == MIPC_ADDR_ENABLE) begin
                ge <= wd;
            end
        end
    end
    ////////////////////////////////////////
    a_glob_block: assert property ((!ge) [*3] |-> !int_req)
        else $error("interrupt offered with global enable clear");
    a_vec_legal: assert property (int_req |-> vec_ok)
        else $error("offered vector not in table");
    a_ack_drop: assert property (int_req && int_ack |=> !int_req)
        else $error("offer not withdrawn after ack");
    a_t0_clear: assert property (take0 |=> timer0_flag_clear)
        else $error("timer 0 flag not cleared on vectoring");
    a_t1_cause: assert property (timer1_flag_clear |-> $past(take1))
        else $error("timer 1 flag clear without vectoring");
    a_t0_pulse: assert property (timer0_flag_clear |=> !timer0_flag_clear)
        else $error("timer 0 flag clear longer than one cycle");
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_pdn_wins: assert property (power.power_down_request |-> !power.sleep_request)
        else $error("sleep and power down both requested");
    c_ack: cover property (int_req && int_ack);
    c_t1: cover property (timer1_flag_clear);
    c_decerr: cover property (s_axi_bvalid && s_axi_bresp == MIPC_RESP_DECERR);
endmodule

// file: tb/tb_top.sv
// Bench: register access, vectoring, priority and power scenarios
`timescale 1ns/1ns
module tb_top;
    import mipc_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] ev = 8'h00;
    logic ret_cmd = 1'h0;
    logic [3:0] lag = 4'h2;
    logic int_ack, int_return, int_req, t0c, t1c, irq;
    logic [15:0] int_vector, got_vec;
    mipc_power_t power;
    int error_cnt = 0;
    int cmp_count = 0;
    int sb [8] = '{0, 1, 2, 3, 4, 4, 5, 5};
    logic [15:0] vt [8] = '{MIPC_VEC_EXT0, MIPC_VEC_TMR0, MIPC_VEC_EXT1, MIPC_VEC_TMR1,
        MIPC_VEC_SER, MIPC_VEC_SER, MIPC_VEC_TMR2, MIPC_VEC_TMR2};
    logic [7:0] pw [4] = '{8'h01, 8'h02, 8'h03, 8'h8C};
    logic [2:0] pe [4] = '{3'h1, 3'h2, 3'h2, 3'h4};

    always #25 aclk = ~aclk;

    mipc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext0_pin(~ev[0]),
        .ext1_pin(~ev[2]), .flags({ev[7:3], ev[1]}), .int_ack, .int_return, .int_req,
        .int_vector, .timer0_flag_clear(t0c), .timer1_flag_clear(t1c), .power, .irq);
    mipc_cpu_model cpu (.aclk, .aresetn, .int_req, .int_vector, .lag, .ret_cmd,
        .int_ack, .int_return, .got_vec);
    ////////////////////////////////////////
    task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 50);
        s_axi_bready <= 1'h0;
        cmp("write", {13'h0, 1'h1, er}, {13'h0, s_axi_bvalid, s_axi_bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 50);
        s_axi_rready <= 1'h0;
        cmp("read", {5'h00, 1'h1, er, e}, {5'h00, s_axi_rvalid, s_axi_rresp, s_axi_rdata[7:0]});
    endtask

    task automatic take(input logic [15:0] v);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (int_ack !== 1'h1 && n < 60);
        cmp("vector", v, (int_ack === 1'h1) ? got_vec : 16'hFFFF);
    endtask

    task automatic idle();
        repeat (12) @(posedge aclk);
        cmp("int_req", 16'h0000, {15'h0, int_req});
    endtask

    task automatic pulse_ret();
        @(posedge aclk);
        ret_cmd <= 1'h1;
        @(posedge aclk);
        ret_cmd <= 1'h0;
    endtask

    task automatic conclude();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        rd(MIPC_ADDR_ENABLE, MIPC_RST_REG8, MIPC_RESP_OKAY);
        rd(MIPC_ADDR_PRIORITY, MIPC_RST_REG8, MIPC_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(MIPC_ADDR_POWER, pw[i], MIPC_RESP_OKAY);
            cmp("power", {13'h0, pe[i]}, {13'h0, power});
        end
        rd(MIPC_ADDR_POWER, 8'h8C, MIPC_RESP_OKAY);
        wr(MIPC_ADDR_POWER, 8'h00, MIPC_RESP_OKAY);
        wr(8'h1C, 8'h00, MIPC_RESP_DECERR);
        rd(8'h1C, 8'h00, MIPC_RESP_DECERR);
        // Global and individual enables, status, mask, irq
        wr(MIPC_ADDR_ENABLE, 8'h3F, MIPC_RESP_OKAY);
        ev <= 8'h02;
        idle();
        wr(MIPC_ADDR_ENABLE, 8'hBD, MIPC_RESP_OKAY);
        idle();
        wr(MIPC_ADDR_ENABLE, 8'h82, MIPC_RESP_OKAY);
        take(MIPC_VEC_TMR0);
        ev <= 8'h00;
        rd(MIPC_ADDR_STATUS, 8'h02, MIPC_RESP_OKAY);
        cmp("irq", 16'h0000, {15'h0, irq});
        wr(MIPC_ADDR_MASK, 8'h3F, MIPC_RESP_OKAY);
        rd(MIPC_ADDR_MASK, 8'h3F, MIPC_RESP_OKAY);
        cmp("irq", 16'h0001, {15'h0, irq});
        wr(MIPC_ADDR_STATUS, 8'h02, MIPC_RESP_OKAY);
        rd(MIPC_ADDR_STATUS, 8'h00, MIPC_RESP_OKAY);
        cmp("irq", 16'h0000, {15'h0, irq});
        pulse_ret();
        // Every event source, slow acknowledge
        lag <= 4'h6;
        for (int i = 0; i < 8; i++) begin
            wr(MIPC_ADDR_ENABLE, 8'h80 | (8'h01 << sb[i]), MIPC_RESP_OKAY);
            ev <= 8'h01 << i;
            take(vt[i]);
            ev <= 8'h00;
            rd(MIPC_ADDR_STATUS, 8'h01 << sb[i], MIPC_RESP_OKAY);
            wr(MIPC_ADDR_STATUS, 8'h3F, MIPC_RESP_OKAY);
            pulse_ret();
        end
        lag <= 4'h1;
        // Falling edge latched while globally disabled
        wr(MIPC_ADDR_EXT_CTRL, 8'h03, MIPC_RESP_OKAY);
        wr(MIPC_ADDR_ENABLE, 8'h05, MIPC_RESP_OKAY);
        ev <= 8'h05;
        repeat (3) @(posedge aclk);
        ev <= 8'h00;
        wr(MIPC_ADDR_ENABLE, 8'h85, MIPC_RESP_OKAY);
        take(MIPC_VEC_EXT0);
        pulse_ret();
        take(MIPC_VEC_EXT1);
        pulse_ret();
        idle();
        // Same level order, blocking, preemption
        wr(MIPC_ADDR_ENABLE, 8'h8A, MIPC_RESP_OKAY);
        ev <= 8'h0A;
        take(MIPC_VEC_TMR0);
        ev <= 8'h08;
        idle();
        pulse_ret();
        take(MIPC_VEC_TMR1);
        ev <= 8'h02;
        idle();
        pulse_ret();
        take(MIPC_VEC_TMR0);
        ev <= 8'h00;
        pulse_ret();
        wr(MIPC_ADDR_PRIORITY, 8'h08, MIPC_RESP_OKAY);
        ev <= 8'h02;
        take(MIPC_VEC_TMR0);
        ev <= 8'h08;
        take(MIPC_VEC_TMR1);
        ev <= 8'h00;
        rd(MIPC_ADDR_STATE, 8'h63, MIPC_RESP_OKAY);
        pulse_ret();
        pulse_ret();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        conclude();
    end
endmodule

bind mipc_top mipc_top_sva u_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .int_ack,
    .int_req, .int_vector, .timer0_flag_clear, .timer1_flag_clear, .power);
